// ===== core/ddrbs_sram_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrbs_consts.svh"
module ddrbs_sram_top (
    input wire logic core_clk_i, // input clock, true phase
    input wire logic rst_b_i, // async reset, active low
    input wire logic c_clk_i, // output clock, link domain
    input wire logic c_clk_n_i, // output clock complement, strap only
    input wire logic read_port_select_n_i, // read port select
    input wire logic write_port_select_n_i, // write port select
    input wire logic [`DDRBS_ADDR_W-1:0] addr_i, // shared address
    input wire logic [`DDRBS_WORD_W-1:0] d_i, // write data word
    input wire logic [`DDRBS_BWS_W-1:0] byte_write_select_n_i, // lanes
    output logic [`DDRBS_WORD_W-1:0] q_o, // read data word
    output logic q_oe_o // read data drive enable
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] strap_s1_r; // first sync stage of clock levels
    logic [1:0] strap_s2_r; // synchronised clock levels
    logic [2:0] sp_cnt_r; // edges since reset release
    ddrbs_pkg::ddrbs_strap_t sp_r; // clock mode decision
    logic ready; // strap decided, requests accepted
    logic rd_go; // read starts at this edge
    logic wr_go; // write starts at this edge
    logic rd_acc_r; // read started at the last edge
    logic wr_acc_r; // write started at the last edge
    ddrbs_pkg::ddrbs_bws_t bws_en; // active-high byte enables
    ddrbs_pkg::ddrbs_word_t d_neg_r; // word caught at falling edge
    ddrbs_pkg::ddrbs_bws_t bws_neg_r; // enables caught at falling edge
    logic w1_r; // first write word due now
    logic w2_r; // second and third words due now
    logic w3_r; // fourth word due now, row commits
    ddrbs_pkg::ddrbs_addr_t wa_r; // write address, collect stage
    ddrbs_pkg::ddrbs_addr_t wa2_r; // write address, commit stage
    ddrbs_pkg::ddrbs_word_t wbuf_r [`DDRBS_BURST]; // gathered words
    ddrbs_pkg::ddrbs_bws_t wen_r [`DDRBS_BURST]; // gathered enables
    ddrbs_pkg::ddrbs_row_t cdata; // row being committed
    ddrbs_pkg::ddrbs_mask_t cmask; // lanes being committed
    ddrbs_pkg::ddrbs_row_t mem_r [`DDRBS_DEPTH]; // the four arrays
    logic rp1_r; // read fetch one edge away
    logic rp2_r; // read fetch due now
    ddrbs_pkg::ddrbs_addr_t ra_r; // read address register
    logic fwd_hit; // fetch meets a commit to the same row
    ddrbs_pkg::ddrbs_row_t fetch_row; // row handed to output stage
    ddrbs_pkg::ddrbs_row_t burst_r; // burst held for the output stage
    logic req_tgl_r; // new burst toggle
    logic ack_s1_r; // first sync stage of acknowledge
    logic ack_s2_r; // synchronised acknowledge
    logic out_busy; // previous burst not yet taken
    logic [`DDRBS_WORD_W-1:0] q_dual; // data from output clock stage
    logic [`DDRBS_WORD_W-1:0] q_single; // data from input clock stage
    logic oe_dual; // enable from output clock stage
    logic oe_single; // enable from input clock stage
    ddrbs_burst_if dual_if (); // handoff to output clock stage
    ddrbs_burst_if single_if (); // handoff to input clock stage

    // masked merge of a new row over an old one
    function automatic ddrbs_pkg::ddrbs_row_t merge_row(
        input ddrbs_pkg::ddrbs_row_t old_v,
        input ddrbs_pkg::ddrbs_row_t new_v,
        input ddrbs_pkg::ddrbs_mask_t en_v);
        ddrbs_pkg::ddrbs_row_t res;
        res = old_v;
        for (int i = 0; i < `DDRBS_MASK_W; i++) begin
            if (en_v[i]) begin // lane enabled, take new byte
                res[i*`DDRBS_HALF_W +: `DDRBS_HALF_W] =
                    new_v[i*`DDRBS_HALF_W +: `DDRBS_HALF_W];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // clock mode strap
    // ------------------------------------------------------------
    // output clock levels into the core domain
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= {c_clk_i, c_clk_n_i};
            strap_s2_r <= strap_s1_r;
        end
    end

    // decide once after release, then hold for good
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_cnt_r <= 3'h0;
            sp_r <= ddrbs_pkg::SP_WAIT;
        end else begin
            unique case (sp_r)
                ddrbs_pkg::SP_WAIT: begin
                    if (sp_cnt_r == `DDRBS_STRAP_WAIT) begin
                        sp_r <= (&strap_s2_r) ? ddrbs_pkg::SP_SINGLE
                                              : ddrbs_pkg::SP_DUAL;
                    end else begin // wait for stable levels
                        sp_cnt_r <= sp_cnt_r + 3'h1;
                    end
                end
                ddrbs_pkg::SP_DUAL, ddrbs_pkg::SP_SINGLE: begin
                    sp_r <= sp_r; // fixed strap
                end
                default: begin // unused code
                    sp_r <= ddrbs_pkg::SP_WAIT;
                end
            endcase
        end
    end

    assign ready = (sp_r != ddrbs_pkg::SP_WAIT);

    // ------------------------------------------------------------
    // port arbitration
    // ------------------------------------------------------------
    // read wins from idle or after a write, write after a read
    assign rd_go = ready && !read_port_select_n_i && !rd_acc_r;
    assign wr_go = ready && !write_port_select_n_i && !wr_acc_r
                   && !rd_go;

    // start flags, sampled on the true input clock only
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_acc_r <= 1'b0;
            wr_acc_r <= 1'b0;
        end else begin
            rd_acc_r <= rd_go;
            wr_acc_r <= wr_go;
        end
    end

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < `DDRBS_BWS_W; g++) begin : g_bws
            assign bws_en[g] = !byte_write_select_n_i[g];
        end
    endgenerate

    // complement edge input registers
    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            d_neg_r <= '0;
            bws_neg_r <= '0;
        end else begin
            d_neg_r <= d_i;
            bws_neg_r <= bws_en;
        end
    end

    // stage flags of the write burst
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w1_r <= 1'b0;
            w2_r <= 1'b0;
            w3_r <= 1'b0;
        end else begin
            w1_r <= wr_go;
            w2_r <= w1_r;
            w3_r <= w2_r;
        end
    end

    // write addresses on the shared bus
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wa_r <= '0;
            wa2_r <= '0;
        end else begin
            if (wr_go) begin // new write address
                wa_r <= addr_i;
            end
            if (w2_r) begin // move to commit stage
                wa2_r <= wa_r;
            end
        end
    end

    // gather the first three words and their enables
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < `DDRBS_BURST; i++) begin
                wbuf_r[i] <= '0;
                wen_r[i] <= '0;
            end
        end else begin
            if (w1_r) begin // lowest word, true edge
                wbuf_r[`DDRBS_LANE0] <= d_i;
                wen_r[`DDRBS_LANE0] <= bws_en;
            end
            if (w2_r) begin // complement then true edge
                wbuf_r[`DDRBS_LANE1] <= d_neg_r;
                wen_r[`DDRBS_LANE1] <= bws_neg_r;
                wbuf_r[`DDRBS_LANE2] <= d_i;
                wen_r[`DDRBS_LANE2] <= bws_en;
            end
        end
    end

    // row to commit: fourth word straight from complement register
    assign cdata = {d_neg_r, wbuf_r[`DDRBS_LANE2],
                    wbuf_r[`DDRBS_LANE1], wbuf_r[`DDRBS_LANE0]};
    assign cmask = {bws_neg_r, wen_r[`DDRBS_LANE2],
                    wen_r[`DDRBS_LANE1], wen_r[`DDRBS_LANE0]};

    // array write, untouched lanes keep their bytes
    always_ff @(posedge core_clk_i) begin
        if (w3_r) begin
            mem_r[wa2_r] <= merge_row(mem_r[wa2_r], cdata, cmask);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read address and fetch timing
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rp1_r <= 1'b0;
            rp2_r <= 1'b0;
            ra_r <= '0;
        end else begin
            rp1_r <= rd_go;
            rp2_r <= rp1_r;
            if (rd_go) begin // same address pins as writes
                ra_r <= addr_i;
            end
        end
    end

    // newest data wins when a commit lands on the fetched row
    assign fwd_hit = w3_r && (wa2_r == ra_r);
    assign fetch_row = fwd_hit ? merge_row(mem_r[ra_r], cdata, cmask)
                               : mem_r[ra_r];

    // hand the burst to the output stage; dropped if still busy
    assign out_busy = (req_tgl_r != ack_s2_r);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            burst_r <= '0;
            req_tgl_r <= 1'b0;
        end else if (rp2_r && !out_busy) begin
            burst_r <= fetch_row;
            req_tgl_r <= !req_tgl_r;
        end
    end

    // acknowledge of the active stage into the core domain
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= (sp_r == ddrbs_pkg::SP_SINGLE) ? single_if.ack_tgl
                                                       : dual_if.ack_tgl;
            ack_s2_r <= ack_s1_r;
        end
    end

    // ------------------------------------------------------------
    // output stages: output clock, or input clock in single mode
    // ------------------------------------------------------------
    assign dual_if.row = burst_r;
    assign single_if.row = burst_r;
    assign dual_if.req_tgl = (sp_r == ddrbs_pkg::SP_DUAL) && req_tgl_r;
    assign single_if.req_tgl = (sp_r == ddrbs_pkg::SP_SINGLE) && req_tgl_r;

    ddrbs_out_stage u_out_dual (
        .clk_i(c_clk_i),
        .rst_b_i(rst_b_i),
        .bus(dual_if.snk),
        .q_o(q_dual),
        .q_oe_o(oe_dual)
    );

    ddrbs_out_stage u_out_single (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .bus(single_if.snk),
        .q_o(q_single),
        .q_oe_o(oe_single)
    );

    // strap fixes the source of read data
    assign q_o = (sp_r == ddrbs_pkg::SP_SINGLE) ? q_single : q_dual;
    assign q_oe_o = (sp_r == ddrbs_pkg::SP_SINGLE) ? oe_single : oe_dual;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_read_no_b2b: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go |=> !rd_go)
        else $error("read started on two consecutive edges");

    a_write_no_b2b: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go |=> !wr_go)
        else $error("write started on two consecutive edges");

    a_read_first_idle: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (ready && !read_port_select_n_i && !write_port_select_n_i
         && !rd_acc_r && !wr_acc_r) |-> (rd_go && !wr_go)
        ##1 (wr_go || write_port_select_n_i))
        else $error("both selects from idle did not read then write");

    a_write_commit_lat: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go |-> ##3 (w3_r && wa2_r == $past(addr_i, 3)))
        else $error("write row not committed three edges later");

    a_word0_capture: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go ##1 w1_r |=> wbuf_r[`DDRBS_LANE0] == $past(d_i))
        else $error("first write word not taken at next edge");

    a_read_fetch_lat: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go |-> ##2 (rp2_r && ra_r == $past(addr_i, 2)))
        else $error("read fetch not two edges after start");

    a_forward_newest: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rp2_r && fwd_hit && !out_busy && (&bws_neg_r))
        |=> burst_r[`DDRBS_ROW_W-1 -: `DDRBS_WORD_W] == $past(d_neg_r))
        else $error("read after write missed the pending word");

    a_desel_write: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        write_port_select_n_i |=> !w1_r)
        else $error("deselected write port started a burst");

    a_strap_fixed: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (sp_r != ddrbs_pkg::SP_WAIT) |=> $stable(sp_r))
        else $error("clock mode changed after the strap decision");

    a_powerup_hiz: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !ready |-> !q_oe_o)
        else $error("read data driven before the strap decision");

    c_read_start: cover property (
        @(posedge core_clk_i) disable iff (!rst_b_i) rd_go);
    c_write_commit: cover property (
        @(posedge core_clk_i) disable iff (!rst_b_i) w3_r);
    c_forward: cover property (
        @(posedge core_clk_i) disable iff (!rst_b_i) rp2_r && fwd_hit);
    c_alternate: cover property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go ##1 wr_go ##1 rd_go);
endmodule // ddrbs_sram_top
`default_nettype wire

// ===== common/ddrbs_consts.svh
`ifndef DDRBS_CONSTS_SVH
`define DDRBS_CONSTS_SVH
// data word and byte-lane geometry
`define DDRBS_WORD_W 18
`define DDRBS_HALF_W 9
`define DDRBS_BWS_W 2
// burst geometry: four words per row
`define DDRBS_BURST 4
`define DDRBS_ROW_W 72
`define DDRBS_MASK_W 8
`define DDRBS_LANE0 0
`define DDRBS_LANE1 1
`define DDRBS_LANE2 2
`define DDRBS_LANE3 3
// array geometry: 256k rows of four words
`define DDRBS_ADDR_W 18
`define DDRBS_DEPTH 262144
// core edges between reset release and strap decision
`define DDRBS_STRAP_WAIT 3'h4
`endif

// ===== common/ddrbs_pkg.sv
`include "ddrbs_consts.svh"
package ddrbs_pkg;
    typedef logic [`DDRBS_WORD_W-1:0] ddrbs_word_t; // one data word
    typedef logic [`DDRBS_ROW_W-1:0] ddrbs_row_t; // four-word burst
    typedef logic [`DDRBS_MASK_W-1:0] ddrbs_mask_t; // byte enables, row
    typedef logic [`DDRBS_BWS_W-1:0] ddrbs_bws_t; // byte enables, word
    typedef logic [`DDRBS_ADDR_W-1:0] ddrbs_addr_t; // burst address
    // output stage sequence
    typedef enum logic [1:0] {
        OS_IDLE = 2'h0,
        OS_FIRST = 2'h1,
        OS_SECOND = 2'h2
    } ddrbs_ostate_t;
    // clock mode strap decision
    typedef enum logic [1:0] {
        SP_WAIT = 2'h0,
        SP_DUAL = 2'h1,
        SP_SINGLE = 2'h2
    } ddrbs_strap_t;
endpackage

// ===== common/ddrbs_burst_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrbs_consts.svh"
// burst handoff from the core to an output stage
interface ddrbs_burst_if;
    logic [`DDRBS_ROW_W-1:0] row; // burst, stable while request pending
    logic req_tgl; // toggles once per new burst
    logic ack_tgl; // follows req_tgl once the burst is taken
    modport src (output row, output req_tgl, input ack_tgl);
    modport snk (input row, input req_tgl, output ack_tgl);
endinterface
`default_nettype wire

// ===== core/ddrbs_out_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrbs_consts.svh"
module ddrbs_out_stage (
    input wire logic clk_i, // output clock, or input clock in single mode, both edges used
    input wire logic rst_b_i, // async reset, active low
    ddrbs_burst_if.snk bus, // burst handoff from the core
    output logic [`DDRBS_WORD_W-1:0] q_o, // read data word
    output logic q_oe_o // read data drive enable
);
    // ------------------------------------------------------------
    // request crossing
    // ------------------------------------------------------------
    logic req_s1_r; // first sync stage, read only by req_s2_r
    logic req_s2_r; // synchronised request toggle
    logic seen_r; // last toggle value taken
    logic ack_r; // acknowledge toggle back to the core
    logic new_burst; // a burst waits to be launched
    ddrbs_pkg::ddrbs_ostate_t st_r; // launch sequence state
    ddrbs_pkg::ddrbs_row_t row_r; // local copy of the burst
    ddrbs_pkg::ddrbs_word_t pos_word_r; // word launched at rising edge
    ddrbs_pkg::ddrbs_word_t neg_word_r; // word launched at falling edge

    // pick one word of a burst
    function automatic ddrbs_pkg::ddrbs_word_t lane(
        input ddrbs_pkg::ddrbs_row_t r, input int idx);
        return r[idx*`DDRBS_WORD_W +: `DDRBS_WORD_W];
    endfunction

    // two flops on the toggle from the core domain
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            req_s1_r <= bus.req_tgl;
            req_s2_r <= req_s1_r;
        end
    end

    assign new_burst = (req_s2_r != seen_r);
    assign bus.ack_tgl = ack_r;

    // ------------------------------------------------------------
    // launch sequence, rising edge half
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ddrbs_pkg::OS_IDLE;
            row_r <= '0;
            pos_word_r <= '0;
            seen_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            unique case (st_r)
                ddrbs_pkg::OS_IDLE, ddrbs_pkg::OS_SECOND: begin
                    if (new_burst) begin // lowest word first, no gap
                        row_r <= bus.row;
                        pos_word_r <= lane(bus.row, `DDRBS_LANE0);
                        seen_r <= req_s2_r;
                        ack_r <= req_s2_r;
                        st_r <= ddrbs_pkg::OS_FIRST;
                    end else begin // burst done, release bus
                        st_r <= ddrbs_pkg::OS_IDLE;
                    end
                end
                ddrbs_pkg::OS_FIRST: begin // third word
                    pos_word_r <= lane(row_r, `DDRBS_LANE2);
                    st_r <= ddrbs_pkg::OS_SECOND;
                end
                default: begin // unused code, recover
                    st_r <= ddrbs_pkg::OS_IDLE;
                end
            endcase
        end
    end

    // falling edge half: second and fourth words
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            neg_word_r <= '0;
        end else if (st_r == ddrbs_pkg::OS_FIRST) begin
            neg_word_r <= lane(row_r, `DDRBS_LANE1);
        end else begin
            neg_word_r <= lane(row_r, `DDRBS_LANE3);
        end
    end

    // clock level picks which launch register shows
    assign q_o = clk_i ? pos_word_r : neg_word_r;
    assign q_oe_o = (st_r != ddrbs_pkg::OS_IDLE);
endmodule // ddrbs_out_stage
`default_nettype wire

// ===== sim/ddrbs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrbs_consts.svh"
// controller model: drives both ports, captures read bursts
module ddrbs_ctl_model (
    input wire logic clk_i, // input clock
    input wire logic c_clk_i, // output clock
    input wire logic [`DDRBS_WORD_W-1:0] q_i, // read data wire
    input wire logic q_oe_i, // read drive enable
    output logic read_port_select_n_o, // read select
    output logic write_port_select_n_o, // write select
    output logic [`DDRBS_ADDR_W-1:0] addr_o, // shared address
    output logic [`DDRBS_WORD_W-1:0] d_o, // write word
    output logic [`DDRBS_BWS_W-1:0] byte_write_select_n_o // lanes
);
    // ------------------------------
    // request and capture tasks
    // ------------------------------
    initial begin
        read_port_select_n_o = 1'b1;
        write_port_select_n_o = 1'b1;
        addr_o = 18'h00000;
        d_o = 18'h00000;
        byte_write_select_n_o = 2'h0;
    end
    // write burst; mode 1 adds a read, mode 2 a second write,
    // mode 3 drives both selects low one edge early so a read goes first
    task automatic wr(input logic [71:0] row, input logic [17:0] a,
        input logic [7:0] m_n, input int mode);
        @(posedge clk_i) #1;
        if (mode == 3) begin // both selects from idle, read first
            read_port_select_n_o = 1'b0;
            write_port_select_n_o = 1'b0;
            addr_o = a + 18'h1;
            @(posedge clk_i) #1;
        end
        write_port_select_n_o = 1'b0;
        addr_o = a;
        for (int n = 0; n < 4; n++) begin
            if (n == 2) @(negedge clk_i) #1;
            else @(posedge clk_i) #1;
            if (n == 0) begin
                write_port_select_n_o = (mode != 2);
                read_port_select_n_o = (mode != 1);
                addr_o = (mode == 2) ? a + 18'h1 : (mode == 1) ? a : ~a;
            end
            if (n == 1) begin
                read_port_select_n_o = 1'b1;
                write_port_select_n_o = 1'b1;
                addr_o = ~addr_o; // released address
            end
            d_o = row[18*n +: 18];
            byte_write_select_n_o = m_n[2*n +: 2];
        end
        @(negedge clk_i) #1;
        d_o = ~d_o; // released data
    endtask
    // read request; dup asks again at the very next edge
    task automatic rd(input logic [17:0] a, input bit dup);
        @(posedge clk_i) #1;
        read_port_select_n_o = 1'b0;
        addr_o = a;
        if (dup) begin
            @(posedge clk_i) #1;
            addr_o = a + 18'h1;
        end
        @(posedge clk_i) #1;
        read_port_select_n_o = 1'b1;
        addr_o = ~addr_o;
    endtask
    // wait for a burst, take one word per output clock edge
    task automatic cap(output logic [71:0] row, output logic tail);
        int k;
        row = 72'h0;
        for (k = 0; k < 64 && q_oe_i !== 1'b1; k++) @(posedge c_clk_i) #1;
        row[17:0] = q_i;
        for (int n = 1; n < 4; n++) begin
            if (n % 2 == 1) @(negedge c_clk_i) #1;
            else @(posedge c_clk_i) #1;
            row[18*n +: 18] = q_i;
        end
        @(posedge c_clk_i) #1;
        tail = q_oe_i;
    endtask
endmodule // ddrbs_ctl_model
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrbs_consts.svh"
module testbench;
    localparam logic [71:0] ROW_A = 72'h0123456789ABCDEF01;
    localparam logic [71:0] ROW_B = 72'hFEDCBA9876543210AB;
    localparam logic [71:0] ROW_C = 72'h3C3C3C5A5A5A96969F;
    localparam logic [17:0] ADDR_A = 18'h3FFFF; // top row
    localparam logic [17:0] ADDR_B = 18'h00010;
    logic core_clk, c_clk, rst_b, tail, q_oe;
    logic c_run = 1'b1; // output clock runs, else both pins held high
    wire logic c_pin = c_run ? c_clk : 1'b1;
    wire logic c_cap = c_run ? c_clk : core_clk;
    logic rd_sel_n, wr_sel_n;
    logic [17:0] addr, d, q;
    logic [1:0] bws_n;
    logic [71:0] got, exp;
    wire logic [17:0] q_bus;
    int err_count = 0, checked = 0, cycles = 0;
    assign q_bus = q_oe ? q : 18'hZZZZZ;
    ddrbs_sram_top dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b),
        .c_clk_i(c_pin), .c_clk_n_i(c_run ? ~c_clk : 1'b1),
        .read_port_select_n_i(rd_sel_n), .write_port_select_n_i(wr_sel_n),
        .addr_i(addr), .d_i(d), .byte_write_select_n_i(bws_n),
        .q_o(q), .q_oe_o(q_oe));
    ddrbs_ctl_model ctl_u (.clk_i(core_clk), .c_clk_i(c_cap),
        .q_i(q_bus), .q_oe_i(q_oe), .read_port_select_n_o(rd_sel_n),
        .write_port_select_n_o(wr_sel_n), .addr_o(addr), .d_o(d),
        .byte_write_select_n_o(bws_n));
    // ------------------------------
    // clocks, checks, scenarios
    // ------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        c_clk = 1'b0;
        #3.7;
        forever #32 c_clk = ~c_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [71:0] seen, input logic [71:0] x);
        checked++;
        if (seen !== x) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, x);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // read a row back and compare it
    task automatic rd_check(input logic [17:0] a, input logic [71:0] x);
        ctl_u.rd(a, 1'b0);
        ctl_u.cap(got, tail);
        check(got, x);
        check({71'h0, tail}, 72'h0);
    endtask
    task automatic t_basic();
        ctl_u.wr(ROW_A, ADDR_A, 8'h00, 0);
        rd_check(ADDR_A, ROW_A);
    endtask
    // disabled lanes keep the old row contents
    task automatic t_mask();
        for (int i = 0; i < 8; i++)
            exp[9*i +: 9] = (8'hA5 >> i) & 1 ? ROW_A[9*i +: 9] : ROW_B[9*i +: 9];
        ctl_u.wr(ROW_B, ADDR_A, 8'hA5, 0);
        rd_check(ADDR_A, exp);
    endtask
    // read one edge after a write to the same row
    task automatic t_fwd();
        ctl_u.wr(ROW_C, ADDR_B, 8'h00, 1);
        ctl_u.cap(got, tail);
        check(got, ROW_C);
    endtask
    // second of two back-to-back writes is dropped
    task automatic t_dupwr();
        ctl_u.wr(ROW_A, ADDR_B + 18'h1, 8'h00, 0);
        ctl_u.wr(ROW_B, ADDR_B, 8'h00, 2);
        rd_check(ADDR_B + 18'h1, ROW_A);
        rd_check(ADDR_B, ROW_B);
    endtask
    // second of two back-to-back reads is ignored; a read taken
    // first must not block the write that both selects ask for
    task automatic t_duprd();
        ctl_u.rd(ADDR_A, 1'b1);
        ctl_u.cap(got, tail);
        check(got, exp);
        ctl_u.wr(ROW_C, ADDR_B, 8'h00, 3);
        ctl_u.cap(got, tail);
        check(got, ROW_A);
        rd_check(ADDR_B, ROW_C);
        repeat (6) @(posedge c_clk);
        check({71'h0, q_oe}, 72'h0);
    endtask
    // second reset with both output clock pins high: single clock mode
    task automatic t_single();
        @(posedge core_clk) #1;
        rst_b = 1'b0;
        c_run = 1'b0;
        repeat (4) @(posedge core_clk);
        check({71'h0, q_oe}, 72'h0);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge core_clk);
        rd_check(ADDR_A, exp);
    endtask
    initial begin
        rst_b = 1'b0;
        repeat (20) @(posedge core_clk);
        check({71'h0, q_oe}, 72'h0);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge core_clk);
        check({71'h0, q_oe}, 72'h0);
        t_basic();
        t_mask();
        t_fwd();
        t_dupwr();
        t_duprd();
        t_single();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
